/* design/wdk_watchdog.sv */
`timescale 1ns/100ps
// keyed watchdog with time-out and key-fault resets
module wdk_watchdog
    import wdk_pkg::*;
#(
    parameter int OSC_DIV_P  = OSC_DIV,
    parameter int KEY_DLY_P  = KEY_DELAY_CYC
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // core events
    input  wire logic       clear_watchdog_instruction_instr,
    input  wire logic       halt_instr,
    input  wire logic       sleep_idle,
    // reset actions
    output logic            full_reset,
    output logic            pc_sp_clear,
    output logic            port_preset,
    // interrupt
    output logic            irq
);
    localparam int KD = KEY_DLY_P;

    logic             tick;        // slow oscillator enable
    logic [7:0]       watchdog_control_r;      // watchdog_control
    logic [7:0]       watchdog_control_nxt;
    logic             kflag_r;     // key_fault_reset_flag
    logic             kflag_nxt;
    logic             to_r;        // timeout_flag
    logic             to_nxt;
    logic             pdf_r;       // power_down_flag
    logic             pdf_nxt;
    logic [CNT_W-1:0] cnt_r;       // watchdog counter
    logic [CNT_W-1:0] cnt_nxt;
    logic             kpend_r;     // key fault pending
    logic             kpend_nxt;
    logic [15:0]      kdly_r;      // key reset delay count
    logic [15:0]      kdly_nxt;
    logic [1:0]       ists_r;      // sticky interrupt status
    logic [1:0]       ists_nxt;
    logic [1:0]       imsk_r;      // interrupt mask
    logic [1:0]       imsk_nxt;
    logic [7:0]       rdata_nxt;
    logic             frst_nxt;
    logic             pcsp_nxt;
    logic             irq_nxt;
    logic [4:0]       key;         // enable_key_field
    logic [3:0]       bitsel;      // counter bit for the period
    logic             key_bad;
    logic             kfire;       // delayed key reset fires now
    logic             to_evt;      // time-out pulse
    logic             wr_watchdog_control;

    // slow oscillator tick
    wdk_tick_div #(
        .DIV (OSC_DIV_P)
    ) u_div (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .tick    (tick)
    );

    // decode of control fields
    always_comb begin
        key     = watchdog_control_r[KEY_LSB +: 5];
        bitsel  = TSEL_BASE + {1'b0, watchdog_control_r[TSEL_LSB +: 3]};
        key_bad = (key != KEY_EN) && (key != KEY_DIS);
        kfire   = kpend_r && (kdly_r == 16'h0000);
        wr_watchdog_control = wr && (addr == ADDR_WATCHDOG_CONTROL);
    end

    // next state of counter, flags, registers and resets
    always_comb begin
        watchdog_control_nxt  = watchdog_control_r;
        kflag_nxt = kflag_r;
        to_nxt    = to_r;
        pdf_nxt   = pdf_r;
        cnt_nxt   = cnt_r;
        kpend_nxt = kpend_r;
        kdly_nxt  = kdly_r;
        imsk_nxt  = imsk_r;
        frst_nxt  = 1'b0;
        pcsp_nxt  = 1'b0;
        to_evt    = 1'b0;
        // counting only with the enable key and on a slow tick
        if (key == KEY_EN && tick) begin
            cnt_nxt = cnt_r + CNT_W'(1);
            // first rise of the selected bit is the time-out
            to_evt  = cnt_nxt[bitsel] && !cnt_r[bitsel];
        end
        if (key == KEY_DIS) begin
            cnt_nxt = '0;
            to_evt  = 1'b0;
        end
        // clear instruction: restart counter, drop power-down
        if (clear_watchdog_instruction_instr) begin
            cnt_nxt = '0;
            to_evt  = 1'b0;
            pdf_nxt = 1'b0;
        end
        // halt: restart counter, power-down set, time-out cleared
        if (halt_instr) begin
            cnt_nxt = '0;
            to_evt  = 1'b0;
            pdf_nxt = 1'b1;
            to_nxt  = 1'b0;
        end
        // software writes
        if (wr_watchdog_control) begin
            watchdog_control_nxt = wdata;
        end
        if (wr && addr == ADDR_RSTF && !wdata[0]) begin
            kflag_nxt = 1'b0;
        end
        if (wr && addr == ADDR_IMSK) begin
            imsk_nxt = wdata[1:0];
        end
        // bad key starts the delayed reset and clears the counter
        if (key_bad && !kpend_r) begin
            kpend_nxt = 1'b1;
            kdly_nxt  = 16'(KD - 1);
            cnt_nxt   = '0;
            to_evt    = 1'b0;
        end else if (kpend_r && !kfire) begin
            kdly_nxt  = kdly_r - 16'h0001;
        end
        // time-out handling by mode
        if (to_evt) begin
            to_nxt   = 1'b1;
            cnt_nxt  = '0;
            pcsp_nxt = 1'b1;
            if (!sleep_idle) begin
                frst_nxt = 1'b1;
                watchdog_control_nxt = WATCHDOG_CONTROL_RST;
            end
        end
        // key fault reset fires: full reset and flag, set wins
        if (kfire) begin
            kflag_nxt = 1'b1;
            kpend_nxt = 1'b0;
            frst_nxt  = 1'b1;
            pcsp_nxt  = 1'b1;
            watchdog_control_nxt  = WATCHDOG_CONTROL_RST;
            cnt_nxt   = '0;
        end
    end

    // interrupt status: read clears, events set and win
    always_comb begin
        ists_nxt = ists_r;
        if (rd && addr == ADDR_ISTS) begin
            ists_nxt = 2'b00;
        end
        ists_nxt[EV_TO]  = ists_nxt[EV_TO]  | to_evt;
        ists_nxt[EV_KEY] = ists_nxt[EV_KEY] | kfire;
        irq_nxt = |(ists_nxt & imsk_nxt);
    end

    // read data, valid the cycle after the strobe
    always_comb begin
        rdata_nxt = 8'h00;
        if (rd) begin
            case (addr)
                ADDR_WATCHDOG_CONTROL: rdata_nxt = watchdog_control_r;
                ADDR_RSTF: rdata_nxt = {7'h00, kflag_r};
                ADDR_STAT: rdata_nxt = {6'h00, pdf_r, to_r};
                ADDR_ISTS: rdata_nxt = {6'h00, ists_r};
                ADDR_IMSK: rdata_nxt = {6'h00, imsk_r};
                default:   rdata_nxt = 8'h00;
            endcase
        end
    end

    // state registers; power-on values
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            watchdog_control_r      <= WATCHDOG_CONTROL_RST;
            kflag_r     <= 1'b0;
            to_r        <= 1'b0;
            pdf_r       <= 1'b0;
            cnt_r       <= '0;
            kpend_r     <= 1'b0;
            kdly_r      <= 16'h0000;
            ists_r      <= 2'b00;
            imsk_r      <= 2'b00;
            rdata       <= 8'h00;
            full_reset  <= 1'b1;
            pc_sp_clear <= 1'b1;
            port_preset <= 1'b1;
            irq         <= 1'b0;
        end else begin
            watchdog_control_r      <= watchdog_control_nxt;
            kflag_r     <= kflag_nxt;
            to_r        <= to_nxt;
            pdf_r       <= pdf_nxt;
            cnt_r       <= cnt_nxt;
            kpend_r     <= kpend_nxt;
            kdly_r      <= kdly_nxt;
            ists_r      <= ists_nxt;
            imsk_r      <= imsk_nxt;
            rdata       <= rdata_nxt;
            full_reset  <= frst_nxt;
            pc_sp_clear <= pcsp_nxt;
            port_preset <= frst_nxt;
            irq         <= irq_nxt;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_key_armed;
        !kpend_r ##1 kpend_r;
    endsequence
    sequence s_key_fired;
        full_reset && kflag_r;
    endsequence

    a_key_delay_reset: assert property (
        s_key_armed |-> ##[1:KD] s_key_fired)
        else $error("key fault did not reset in time");
    a_key_flag_hold: assert property (
        kflag_r && !(wr && addr == ADDR_RSTF && !wdata[0]) |=> kflag_r)
        else $error("key flag dropped without a zero write");
    a_flag_upper_zero: assert property (
        rd && addr == ADDR_RSTF |=> rdata[7:1] == 7'h00 &&
        rdata[0] == $past(kflag_r))
        else $error("reset flag read wrong");
    // a key fault armed before the disable write still fires, so skip it
    a_disable_stops: assert property (
        key == KEY_DIS && !wr_watchdog_control && !kfire |=> cnt_r == '0 &&
        !pc_sp_clear)
        else $error("counter ran while disabled");
    a_enable_counts: assert property (
        key == KEY_EN && tick && !to_evt && !clear_watchdog_instruction_instr &&
        !halt_instr && !kfire |=> cnt_r == $past(cnt_r) + CNT_W'(1))
        else $error("enabled counter did not step");
    a_normal_timeout: assert property (
        to_evt && !sleep_idle && !kfire |=> full_reset && to_r &&
        watchdog_control_r == WATCHDOG_CONTROL_RST)
        else $error("normal time-out did not reset");
    a_sleep_timeout: assert property (
        to_evt && sleep_idle && !kfire |=> pc_sp_clear &&
        !full_reset && to_r && pdf_r == $past(pdf_r))
        else $error("sleep time-out acted wrongly");
    a_halt_flags: assert property (
        halt_instr |=> pdf_r && !to_r && cnt_r == '0)
        else $error("halt did not set flags");
    a_clr_counter: assert property (
        clear_watchdog_instruction_instr && !halt_instr |=> !pdf_r && cnt_r == '0)
        else $error("clear instruction failed");
    a_timeout_pulse: assert property (
        to_evt |=> !to_evt && cnt_r == '0)
        else $error("time-out longer than one cycle");

    // normal time-out with nothing pending: reset actions last one cycle
    sequence s_norm_timeout;
        to_evt && !sleep_idle && !kpend_r;
    endsequence
    sequence s_reset_pulse;
        full_reset && port_preset ##1 !full_reset;
    endsequence
    a_reset_one_cycle: assert property (
        s_norm_timeout |=> s_reset_pulse)
        else $error("reset action not one cycle long");

    // a time-out leaves the power-down flag as it was
    a_to_keeps_pdf: assert property (
        to_evt |=> pdf_r == $past(pdf_r))
        else $error("time-out changed power-down flag");

    // key fault reset: full reset, flag set, control preset
    a_key_fire_acts: assert property (
        kfire |=> full_reset && pc_sp_clear && port_preset &&
        kflag_r && watchdog_control_r == WATCHDOG_CONTROL_RST)
        else $error("key fault reset incomplete");

    // key fault reset leaves time-out and power-down flags alone
    a_key_keeps_flags: assert property (
        kfire && !to_evt && !halt_instr && !clear_watchdog_instruction_instr |=>
        to_r == $past(to_r) && pdf_r == $past(pdf_r))
        else $error("key fault reset changed status flags");

    // writing zero to the key fault flag clears it
    a_flag_zero_clear: assert property (
        wr && addr == ADDR_RSTF && !wdata[0] && !kfire |=> !kflag_r)
        else $error("key flag not cleared by zero write");

    // clear instruction leaves the time-out flag as it was
    a_clr_keeps_to: assert property (
        clear_watchdog_instruction_instr && !halt_instr |=> to_r == $past(to_r))
        else $error("clear instruction changed time-out flag");

    // sleep time-out leaves the control register alone
    a_sleep_keeps_ctl: assert property (
        to_evt && sleep_idle && !kfire && !wr_watchdog_control |=>
        watchdog_control_r == $past(watchdog_control_r))
        else $error("sleep time-out changed control register");

    // halt with the disable key: counter cleared and stays stopped
    a_halt_stays_off: assert property (
        halt_instr && key == KEY_DIS && !wr_watchdog_control |=>
        cnt_r == '0 ##1 cnt_r == '0)
        else $error("disabled counter ran after halt");

    // read data stand only in the cycle after a read strobe
    a_read_idle_zero: assert property (
        !rd |=> rdata == 8'h00)
        else $error("read data outside the answer cycle");
endmodule

/* design/wdk_pkg.sv */
package wdk_pkg;
    // clock and slow oscillator rates
    localparam int CLK_HZ        = 250_000_000;
    localparam int OSC_HZ        = 32_000;
    localparam int OSC_DIV       = CLK_HZ / OSC_HZ;
    // key reset delay, time and derived cycles (rounded up)
    localparam int KEY_DELAY_NS  = 1000;
    localparam int KEY_DELAY_CYC = (KEY_DELAY_NS * (CLK_HZ / 1_000_000)
                                    + 999) / 1000;
    // register index on the plain port
    localparam logic [2:0] ADDR_WATCHDOG_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_RSTF = 3'h1;
    localparam logic [2:0] ADDR_STAT = 3'h2;
    localparam logic [2:0] ADDR_ISTS = 3'h3;
    localparam logic [2:0] ADDR_IMSK = 3'h4;
    // control register layout and reset
    localparam int         KEY_LSB   = 3;
    localparam int         TSEL_LSB  = 0;
    localparam logic [7:0] WATCHDOG_CONTROL_RST  = 8'h53;
    localparam logic [4:0] KEY_EN    = 5'h0a;
    localparam logic [4:0] KEY_DIS   = 5'h15;
    // counter geometry
    localparam int         CNT_W     = 16;
    localparam logic [3:0] TSEL_BASE = 4'h8;
    // status bit positions and port reset value
    localparam int         ST_TO     = 0;
    localparam int         ST_PDF    = 1;
    localparam int         EV_TO     = 0;
    localparam int         EV_KEY    = 1;
    localparam logic [7:0] PORT_RST  = 8'hff;
endpackage

/* design/wdk_tick_div.sv */
`timescale 1ns/100ps
// divides the system clock down to one-cycle oscillator tick enables
module wdk_tick_div
    import wdk_pkg::*;
#(
    parameter int DIV = OSC_DIV
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // one-cycle enable at the slow rate
    output logic      tick
);
    localparam int W = $clog2(DIV);

    logic [W-1:0] cnt_r;   // divider count
    logic [W-1:0] cnt_nxt;
    logic         tick_nxt;

    // wrap at DIV-1 and flag the wrap
    always_comb begin
        tick_nxt = (cnt_r == W'(DIV - 1));
        cnt_nxt  = tick_nxt ? '0 : cnt_r + W'(1);
    end

    // register count and tick
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/100ps
// self-checking bench for the keyed watchdog, register and event calls
module tb_top;
    import wdk_pkg::*;
    // shortened slow tick and key delay keep the run brief
    localparam int DIV   = 4;
    localparam int KDL   = 4;
    localparam int T0    = 256 * DIV;  // select 0 period in clocks
    localparam int LIMIT = 20000;      // hang ceiling in clocks
    // design ports
    logic       clk_sys;
    logic       rstn;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       clear_watchdog_instruction_instr;
    logic       halt_instr;
    logic       sleep_idle;
    logic       full_reset;
    logic       pc_sp_clear;
    logic       port_preset;
    logic       irq;
    // bench state
    int         miscompares;
    int         comparisons;
    int         cyc;
    int         rst_seen;          // full reset pulses after release
    int         n;
    int         r0;
    logic [7:0] v;
    logic       q;

    wdk_watchdog #(.OSC_DIV_P(DIV), .KEY_DLY_P(KDL)) u_wdk_watchdog (
        .clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .clear_watchdog_instruction_instr(clear_watchdog_instruction_instr),
        .halt_instr(halt_instr), .sleep_idle(sleep_idle),
        .full_reset(full_reset), .pc_sp_clear(pc_sp_clear),
        .port_preset(port_preset), .irq(irq));

    // 250 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // counts reset pulses and cuts a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (rstn === 1'b1 && full_reset === 1'b1) rst_seen <= rst_seen + 1;
        if (cyc == LIMIT) begin
            miscompares++;
            complete_run();
        end
    end

    // compares a seen byte with the expected one, reports a mismatch
    task automatic check_byte(input string nm, input logic [7:0] got,
                              input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one-cycle write strobe
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr    <= 1'b0;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    // one-cycle instruction pulse: 1 clear, 0 halt
    task automatic pulse(input bit clr);
        @(posedge clk_sys);
        if (clr) clear_watchdog_instruction_instr <= 1'b1;
        else halt_instr <= 1'b1;
        @(posedge clk_sys);
        clear_watchdog_instruction_instr <= 1'b0;
        halt_instr    <= 1'b0;
    endtask

    // waits, bounded, for a reset action pulse
    task automatic wait_act(input int lim);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (full_reset !== 1'b1 && pc_sp_clear !== 1'b1 && n < lim);
    endtask

    // closing report and verdict
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        {addr, wdata, wr, rd, clear_watchdog_instruction_instr, halt_instr, sleep_idle} = '0;
        {miscompares, comparisons, cyc, rst_seen} = '0;
        rstn = 1'b0;
        @(posedge clk_sys);
        #1 check_byte("reset outs", {5'h0, full_reset, pc_sp_clear,
                      port_preset}, 8'h07);
        @(posedge clk_sys);
        rstn <= 1'b1;
        rd_reg(ADDR_WATCHDOG_CONTROL, v);
        check_byte("control", v, 8'h53);
        rd_reg(ADDR_RSTF, v);
        check_byte("rst flag", v, 8'h00);
        rd_reg(ADDR_STAT, v);
        check_byte("status", v, 8'h00);
        rd_reg(3'h5, v);
        check_byte("unmapped", v, 8'h00);
        $display("test reset values done");
        // normal time-out at the shortest period
        wr_reg(ADDR_WATCHDOG_CONTROL, {KEY_EN, 3'h0});
        pulse(1);
        wait_act(T0 + 16);
        check_byte("acts", {full_reset, pc_sp_clear, port_preset},
                   8'h07);
        check_byte("period", 8'(n >= T0 - 4 && n <= T0 + 8),
                   8'h01);
        @(posedge clk_sys);
        #1 check_byte("one pulse", {7'h0, full_reset}, 8'h00);
        rd_reg(ADDR_STAT, v);
        check_byte("status", v, 8'h01);
        rd_reg(ADDR_WATCHDOG_CONTROL, v);
        check_byte("control", v, 8'h53);
        // interrupt masked then unmasked, then cleared by read
        wr_reg(ADDR_IMSK, 8'h00);
        @(posedge clk_sys);
        #1 q = irq;
        wr_reg(ADDR_IMSK, 8'h03);
        @(posedge clk_sys);
        #1 check_byte("irq mask", {7'h0, q ^ irq}, 8'h01);
        rd_reg(ADDR_ISTS, v);
        check_byte("irq status", v, 8'h01);
        @(posedge clk_sys);
        #1 check_byte("irq clear", {7'h0, irq}, 8'h00);
        $display("test normal time-out done");
        // disable key holds off time-outs
        r0 = rst_seen;
        wr_reg(ADDR_WATCHDOG_CONTROL, {KEY_DIS, 3'h0});
        repeat (2 * T0) @(posedge clk_sys);
        check_byte("disabled", 8'(rst_seen - r0), 8'h00);
        // clearing before the period ends keeps it alive
        wr_reg(ADDR_WATCHDOG_CONTROL, {KEY_EN, 3'h0});
        pulse(1);
        repeat (3) begin
            repeat (T0 - 200) @(posedge clk_sys);
            pulse(1);
        end
        check_byte("kept alive", 8'(rst_seen - r0), 8'h00);
        $display("test disable and clear done");
        // halt, then time-out while asleep
        pulse(0);
        rd_reg(ADDR_STAT, v);
        check_byte("halt stat", v, 8'h02);
        @(posedge clk_sys);
        sleep_idle <= 1'b1;
        wait_act(T0 + 32);
        check_byte("sleep acts", {full_reset, pc_sp_clear, port_preset},
                   8'h02);
        @(posedge clk_sys);
        sleep_idle <= 1'b0;
        rd_reg(ADDR_STAT, v);
        check_byte("sleep stat", v, 8'h03);
        pulse(1);
        rd_reg(ADDR_STAT, v);
        check_byte("clr stat", v, 8'h01);
        rd_reg(ADDR_ISTS, v);
        check_byte("irq sleep", v, 8'h01);
        $display("test halt and sleep done");
        // bad key: delayed reset and sticky flag
        wr_reg(ADDR_WATCHDOG_CONTROL, 8'h00);
        wait_act(KDL + 8);
        check_byte("key reset", {full_reset, pc_sp_clear, port_preset},
                   8'h07);
        rd_reg(ADDR_RSTF, v);
        check_byte("key flag", v, 8'h01);
        wr_reg(ADDR_RSTF, 8'hff);
        rd_reg(ADDR_RSTF, v);
        check_byte("flag w1", v, 8'h01);
        wr_reg(ADDR_RSTF, 8'h00);
        rd_reg(ADDR_RSTF, v);
        check_byte("flag w0", v, 8'h00);
        rd_reg(ADDR_ISTS, v);
        check_byte("irq key", v, 8'h02);
        $display("test key fault done");
        // next select doubles the period
        wr_reg(ADDR_WATCHDOG_CONTROL, {KEY_EN, 3'h1});
        pulse(1);
        wait_act(2 * T0 + 16);
        check_byte("period 1", 8'(n >= 2 * T0 - 4 && n <= 2 * T0 + 8),
                   8'h01);
        $display("test select done");
        complete_run();
    end
endmodule
